// file: rtl/fwp_pkg.sv
// Package for the flash write-protection block: opcodes, status layout,
// array geometry, types and reset values.
// Assumes a byte-serial command stream decoded upstream into bit strobes.
package fwp_pkg;

  localparam int unsigned ADDR_W = 19;
  localparam logic [18:0] ADDR_MAX = 19'h7FFFF;

  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD     = 8'h06;
  localparam logic [7:0] OP_WRDI     = 8'h04;
  localparam logic [7:0] OP_WRSR     = 8'h01;
  localparam logic [7:0] OP_PP       = 8'h02;
  localparam logic [7:0] OP_PE       = 8'h81;
  localparam logic [7:0] OP_SE       = 8'h20;
  localparam logic [7:0] OP_BE32     = 8'h52;
  localparam logic [7:0] OP_BE64     = 8'hD8;
  localparam logic [7:0] OP_CE_A     = 8'h60;
  localparam logic [7:0] OP_CE_B     = 8'hC7;
  localparam logic [7:0] OP_SUSP_A   = 8'h75;
  localparam logic [7:0] OP_SUSP_B   = 8'hB0;
  localparam logic [7:0] OP_RES_A    = 8'h7A;
  localparam logic [7:0] OP_RES_B    = 8'h30;
  localparam logic [7:0] OP_DP       = 8'hB9;
  localparam logic [7:0] OP_RDP      = 8'hAB;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_SEC_ERA  = 8'h44;

  // Span sizes as log2 of bytes
  localparam logic [4:0] LOG_PAGE  = 5'd8;
  localparam logic [4:0] LOG_SECT  = 5'd12;
  localparam logic [4:0] LOG_BLK32 = 5'd15;
  localparam logic [4:0] LOG_BLK64 = 5'd16;

  // Command lengths in bits
  localparam logic [11:0] LEN_OPC  = 12'd8;
  localparam logic [11:0] LEN_SR1  = 12'd16;
  localparam logic [11:0] LEN_SR2  = 12'd24;
  localparam logic [11:0] LEN_ADDR = 12'd32;
  localparam logic [11:0] LEN_DATA = 12'd40;
  localparam logic [11:0] LEN_SAT  = 12'hFFF;

  // Status bit positions
  localparam int unsigned SB_WIP  = 0;
  localparam int unsigned SB_WEL  = 1;
  localparam int unsigned SB_BP0  = 2;
  localparam int unsigned SB_STATUS_GUARD_BIT0 = 7;
  localparam int unsigned SB_STATUS_GUARD_BIT1 = 8;
  localparam int unsigned SB_PROGRAM_SUSPENDED_FLAG = 10;
  localparam int unsigned SB_LB0  = 11;
  localparam int unsigned SB_CMP  = 14;
  localparam int unsigned SB_ERASE_SUSPENDED_FLAG = 15;

  // Unprogrammed defaults
  localparam logic [4:0] RST_BP  = 5'h00;
  localparam logic [1:0] RST_SRP = 2'h0;
  localparam logic [2:0] RST_LB  = 3'h0;
  localparam logic       RST_CMP = 1'b0;

  typedef enum logic [2:0] {
    FWP_STANDBY,
    FWP_BUSY_PROG,
    FWP_BUSY_ERASE,
    FWP_BUSY_STATUS,
    FWP_SUSP_PROG,
    FWP_SUSP_ERASE,
    FWP_DEEP_DOWN
  } fwp_mode_e;

  typedef enum logic [2:0] {
    FWP_OP_PROGRAM,
    FWP_OP_ERASE,
    FWP_OP_CHIP_ERASE,
    FWP_OP_STATUS,
    FWP_OP_SEC_PROGRAM,
    FWP_OP_SEC_ERASE,
    FWP_OP_SUSPEND,
    FWP_OP_RESUME
  } fwp_kind_e;

  typedef struct packed {
    logic frame_start;
    logic bit_valid;
    logic bit_data;
    logic frame_end;
  } fwp_bits_s;

  typedef struct packed {
    logic        valid;
    fwp_kind_e   kind;
    logic [18:0] first;
    logic [18:0] last;
  } fwp_op_s;

  typedef struct packed {
    logic        any;
    logic [18:0] lo;
    logic [18:0] hi;
  } fwp_range_s;

endpackage

// file: rtl/fwp_protect.sv
// Write-protection and status-flag logic of a small serial NOR flash.
// Expects bit strobes already sampled from the serial pins, one per bit,
// framed by chip-select edges, and an array engine that reports completion.
`timescale 1ns/100ps

// Function
// - Three one-time lock bits at S13..S11, zero when unprogrammed.
// - Lock bits only set by status write; set bit makes security register read-only.
// - Complement bit at S14, default zero, alters block-protect mapping.
// - Erase suspend sets S15 flag, program suspend sets S10 flag.
// - Resume or power-up clears both suspend flags.
// - Power-up puts command state into standby, nothing in progress.
// - Data-changing commands not ending on a byte boundary are rejected.
// - Data-changing commands need write-enable latch set; refused otherwise.
// - Hardware protection with pin low blocks protect and guard bit writes.
// - Deep power-down ignores all commands except release.
// - Program or erase touching protected range is ignored.
// - Complement zero: 000 none; bit2 without bit4 all; bit4 with 111 all.
// - Complement zero, 000xx: top 64KB, 128KB, 256KB.
// - Complement zero, 010xx: bottom 64KB, 128KB, 256KB.
// - Complement zero, 10 patterns: top 4KB, 8KB, 16KB, or 32KB.
// - Complement zero, 11 patterns: same sizes at bottom.
// - Complement one protects exactly the complement of the zero case.
// - Chip erase runs only when nothing is protected.
// - Guard 01 with pin low locks status; pin high allows after enable.
module fwp_protect (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire fwp_pkg::fwp_bits_s i_bits,
  input  wire logic             i_wp_n,
  input  wire logic             i_op_done,
  output logic [15:0]           o_status,
  output fwp_pkg::fwp_op_s      o_op,
  output logic                  o_reject
);

  typedef struct packed {
    fwp_pkg::fwp_mode_e mode;
    logic               write_enable_latch;
    logic [4:0]         bp;
    logic [1:0]         srp;
    logic [2:0]         lb;
    logic               cmp;
    logic [11:0]        cnt;
    logic [7:0]         opc;
    logic [23:0]        sh;
    logic [23:0]        addr;
    fwp_pkg::fwp_op_s   op;
    logic               reject;
  } fwp_state_s;

  fwp_state_s st;
  fwp_state_s next_st;

  // Protected range with complement clear
  function automatic fwp_pkg::fwp_range_s base_range(input logic [4:0] bp);
    fwp_pkg::fwp_range_s r;
    logic [4:0]  sz;
    logic [18:0] mask;
    r    = '{any: 1'b0, lo: 19'h00000, hi: fwp_pkg::ADDR_MAX};
    sz   = 5'd0;
    mask = 19'h00000;
    if (bp[2:0] == 3'b000)
    begin
      r.any = 1'b0;
    end
    else if ((!bp[4] && bp[2]) || (bp[4] && bp[2:0] == 3'b111))
    begin
      r.any = 1'b1;
    end
    else
    begin
      r.any = 1'b1;
      if (!bp[4])
        sz = 5'd15 + {3'b000, bp[1:0]};
      else if (bp[2])
        sz = 5'd15;
      else
        sz = 5'd11 + {3'b000, bp[1:0]};
      mask = (19'h00001 << sz) - 19'h00001;
      if (!bp[3])
        r.lo = fwp_pkg::ADDR_MAX - mask;
      else
        r.hi = mask;
    end
    return r;
  endfunction

  // Effective range after the complement bit
  function automatic fwp_pkg::fwp_range_s prot_range(input logic [4:0] bp,
                                                     input logic       cmp);
    fwp_pkg::fwp_range_s b;
    fwp_pkg::fwp_range_s r;
    b = base_range(bp);
    r = b;
    if (cmp)
    begin
      r = '{any: 1'b1, lo: 19'h00000, hi: fwp_pkg::ADDR_MAX};
      if (b.any && b.lo == 19'h00000 && b.hi == fwp_pkg::ADDR_MAX)
        r.any = 1'b0;
      else if (b.any && b.lo == 19'h00000)
        r.lo = b.hi + 19'h00001;
      else if (b.any)
        r.hi = b.lo - 19'h00001;
    end
    return r;
  endfunction

  // Aligned span containing addr
  function automatic fwp_pkg::fwp_range_s span(input logic [18:0] addr,
                                               input logic [4:0]  lg);
    fwp_pkg::fwp_range_s r;
    logic [18:0] mask;
    mask  = (19'h00001 << lg) - 19'h00001;
    r.any = 1'b1;
    r.lo  = addr & ~mask;
    r.hi  = (addr & ~mask) | mask;
    return r;
  endfunction

  function automatic logic overlaps(input fwp_pkg::fwp_range_s p,
                                    input fwp_pkg::fwp_range_s t);
    return p.any && !(t.hi < p.lo || t.lo > p.hi);
  endfunction

  // Status word assembled from state flops
  always_comb
  begin
    o_status                          = 16'h0000;
    o_status[fwp_pkg::SB_WIP]         = st.mode inside {fwp_pkg::FWP_BUSY_PROG,
                                                        fwp_pkg::FWP_BUSY_ERASE,
                                                        fwp_pkg::FWP_BUSY_STATUS};
    o_status[fwp_pkg::SB_WEL]         = st.write_enable_latch;
    o_status[fwp_pkg::SB_BP0 +: 5]    = st.bp;
    o_status[fwp_pkg::SB_STATUS_GUARD_BIT0]        = st.srp[0];
    o_status[fwp_pkg::SB_STATUS_GUARD_BIT1]        = st.srp[1];
    o_status[fwp_pkg::SB_PROGRAM_SUSPENDED_FLAG]        = (st.mode == fwp_pkg::FWP_SUSP_PROG);
    o_status[fwp_pkg::SB_LB0 +: 3]    = st.lb;
    o_status[fwp_pkg::SB_CMP]         = st.cmp;
    o_status[fwp_pkg::SB_ERASE_SUSPENDED_FLAG]        = (st.mode == fwp_pkg::FWP_SUSP_ERASE);
  end

  assign o_op     = st.op;
  assign o_reject = st.reject;

  always_comb
  begin
    fwp_pkg::fwp_range_s prot;
    fwp_pkg::fwp_range_s tgt;
    logic       byte_ok;
    logic       changes;
    logic       allow;
    logic       sr_locked;
    logic       busy;
    logic [1:0] sec_idx;
    logic [7:0] sr_lo;
    logic [7:0] sr_hi;
    prot      = prot_range(st.bp, st.cmp);
    tgt       = span(st.addr[18:0], fwp_pkg::LOG_PAGE);
    byte_ok   = (st.cnt[2:0] == 3'b000) && (st.cnt != fwp_pkg::LEN_SAT);
    changes   = 1'b0;
    allow     = 1'b0;
    sec_idx   = st.addr[13:12];
    sr_lo     = 8'h00;
    sr_hi     = 8'h00;
    busy      = st.mode inside {fwp_pkg::FWP_BUSY_PROG, fwp_pkg::FWP_BUSY_ERASE,
                                fwp_pkg::FWP_BUSY_STATUS};
    sr_locked = st.srp[1] || (st.srp[0] && !i_wp_n);

    next_st           = st;
    next_st.op.valid  = 1'b0;
    next_st.reject    = 1'b0;

    // Bit collection
    if (i_bits.frame_start)
    begin
      next_st.cnt = 12'd0;
      next_st.sh  = 24'h000000;
    end
    else if (i_bits.bit_valid)
    begin
      if (st.cnt != fwp_pkg::LEN_SAT)
        next_st.cnt = st.cnt + 12'd1;
      if (st.cnt < fwp_pkg::LEN_OPC)
        next_st.opc = {st.opc[6:0], i_bits.bit_data};
      else if (st.cnt < fwp_pkg::LEN_ADDR)
        next_st.sh = {st.sh[22:0], i_bits.bit_data};
      if (st.cnt == fwp_pkg::LEN_ADDR - 12'd1)
        next_st.addr = {st.sh[22:0], i_bits.bit_data};
    end

    if (i_op_done && busy)
      next_st.mode = fwp_pkg::FWP_STANDBY;

    // Command decision at chip-select release
    if (i_bits.frame_end && st.cnt >= fwp_pkg::LEN_OPC)
    begin
      if (st.mode == fwp_pkg::FWP_DEEP_DOWN)
      begin
        if (st.opc == fwp_pkg::OP_RDP)
          next_st.mode = fwp_pkg::FWP_STANDBY;
      end
      else
      begin
        unique case (st.opc)
          fwp_pkg::OP_WRITE_ENABLE_CMD:
          begin
            changes = 1'b1;
            allow   = byte_ok && st.cnt == fwp_pkg::LEN_OPC;
            if (allow)
              next_st.write_enable_latch = 1'b1;
          end
          fwp_pkg::OP_WRDI:
          begin
            changes = 1'b1;
            allow   = byte_ok && st.cnt == fwp_pkg::LEN_OPC;
            if (allow)
              next_st.write_enable_latch = 1'b0;
          end
          fwp_pkg::OP_DP:
          begin
            changes = 1'b1;
            allow   = byte_ok && st.cnt == fwp_pkg::LEN_OPC
                      && st.mode == fwp_pkg::FWP_STANDBY;
            if (allow)
              next_st.mode = fwp_pkg::FWP_DEEP_DOWN;
          end
          fwp_pkg::OP_SUSP_A, fwp_pkg::OP_SUSP_B:
          begin
            changes = 1'b1;
            allow   = byte_ok && st.cnt == fwp_pkg::LEN_OPC
                      && st.mode inside {fwp_pkg::FWP_BUSY_PROG, fwp_pkg::FWP_BUSY_ERASE};
            if (allow)
            begin
              next_st.mode = (st.mode == fwp_pkg::FWP_BUSY_ERASE)
                             ? fwp_pkg::FWP_SUSP_ERASE : fwp_pkg::FWP_SUSP_PROG;
              next_st.op   = '{valid: 1'b1, kind: fwp_pkg::FWP_OP_SUSPEND,
                               first: 19'h00000, last: 19'h00000};
            end
          end
          fwp_pkg::OP_RES_A, fwp_pkg::OP_RES_B:
          begin
            changes = 1'b1;
            allow   = byte_ok && st.cnt == fwp_pkg::LEN_OPC
                      && st.mode inside {fwp_pkg::FWP_SUSP_PROG, fwp_pkg::FWP_SUSP_ERASE};
            if (allow)
            begin
              next_st.mode = (st.mode == fwp_pkg::FWP_SUSP_ERASE)
                             ? fwp_pkg::FWP_BUSY_ERASE : fwp_pkg::FWP_BUSY_PROG;
              next_st.op   = '{valid: 1'b1, kind: fwp_pkg::FWP_OP_RESUME,
                               first: 19'h00000, last: 19'h00000};
            end
          end
          fwp_pkg::OP_WRSR:
          begin
            changes = 1'b1;
            sr_lo   = (st.cnt == fwp_pkg::LEN_SR1) ? st.sh[7:0] : st.sh[15:8];
            sr_hi   = st.sh[7:0];
            allow   = byte_ok && st.write_enable_latch && !sr_locked && st.mode == fwp_pkg::FWP_STANDBY
                      && (st.cnt == fwp_pkg::LEN_SR1 || st.cnt == fwp_pkg::LEN_SR2);
            if (allow)
            begin
              next_st.bp     = sr_lo[fwp_pkg::SB_BP0 +: 5];
              next_st.srp[0] = sr_lo[fwp_pkg::SB_STATUS_GUARD_BIT0];
              if (st.cnt == fwp_pkg::LEN_SR2)
              begin
                next_st.srp[1] = sr_hi[fwp_pkg::SB_STATUS_GUARD_BIT1 - 8];
                next_st.lb     = st.lb | sr_hi[fwp_pkg::SB_LB0 - 8 +: 3];
                next_st.cmp    = sr_hi[fwp_pkg::SB_CMP - 8];
              end
              next_st.mode = fwp_pkg::FWP_BUSY_STATUS;
              next_st.op   = '{valid: 1'b1, kind: fwp_pkg::FWP_OP_STATUS,
                               first: 19'h00000, last: 19'h00000};
            end
          end
          fwp_pkg::OP_CE_A, fwp_pkg::OP_CE_B:
          begin
            changes = 1'b1;
            allow   = byte_ok && st.write_enable_latch && st.cnt == fwp_pkg::LEN_OPC
                      && st.mode == fwp_pkg::FWP_STANDBY && !prot.any;
            if (allow)
            begin
              next_st.mode = fwp_pkg::FWP_BUSY_ERASE;
              next_st.op   = '{valid: 1'b1, kind: fwp_pkg::FWP_OP_CHIP_ERASE,
                               first: 19'h00000, last: fwp_pkg::ADDR_MAX};
            end
          end
          fwp_pkg::OP_PP, fwp_pkg::OP_PE, fwp_pkg::OP_SE,
          fwp_pkg::OP_BE32, fwp_pkg::OP_BE64:
          begin
            changes = 1'b1;
            if (st.opc == fwp_pkg::OP_SE)
              tgt = span(st.addr[18:0], fwp_pkg::LOG_SECT);
            else if (st.opc == fwp_pkg::OP_BE32)
              tgt = span(st.addr[18:0], fwp_pkg::LOG_BLK32);
            else if (st.opc == fwp_pkg::OP_BE64)
              tgt = span(st.addr[18:0], fwp_pkg::LOG_BLK64);
            allow = byte_ok && st.write_enable_latch && st.mode == fwp_pkg::FWP_STANDBY
                    && ((st.opc == fwp_pkg::OP_PP) ? st.cnt >= fwp_pkg::LEN_DATA
                                                   : st.cnt == fwp_pkg::LEN_ADDR)
                    && !overlaps(prot, tgt);
            if (allow)
            begin
              next_st.mode = (st.opc == fwp_pkg::OP_PP)
                             ? fwp_pkg::FWP_BUSY_PROG : fwp_pkg::FWP_BUSY_ERASE;
              next_st.op   = '{valid: 1'b1,
                               kind:  (st.opc == fwp_pkg::OP_PP) ? fwp_pkg::FWP_OP_PROGRAM
                                                                 : fwp_pkg::FWP_OP_ERASE,
                               first: tgt.lo, last: tgt.hi};
            end
          end
          fwp_pkg::OP_SEC_PROG, fwp_pkg::OP_SEC_ERA:
          begin
            changes = 1'b1;
            allow   = byte_ok && st.write_enable_latch && st.mode == fwp_pkg::FWP_STANDBY
                      && sec_idx != 2'b00 && !st.lb[sec_idx - 2'd1]
                      && ((st.opc == fwp_pkg::OP_SEC_PROG) ? st.cnt >= fwp_pkg::LEN_DATA
                                                           : st.cnt == fwp_pkg::LEN_ADDR);
            if (allow)
            begin
              next_st.mode = (st.opc == fwp_pkg::OP_SEC_PROG)
                             ? fwp_pkg::FWP_BUSY_PROG : fwp_pkg::FWP_BUSY_ERASE;
              next_st.op   = '{valid: 1'b1,
                               kind:  (st.opc == fwp_pkg::OP_SEC_PROG)
                                      ? fwp_pkg::FWP_OP_SEC_PROGRAM
                                      : fwp_pkg::FWP_OP_SEC_ERASE,
                               first: st.addr[18:0], last: st.addr[18:0]};
            end
          end
          default:
          begin
            changes = 1'b0;
          end
        endcase
        // Latch drops after any accepted write-type command
        if (allow && !(st.opc inside {fwp_pkg::OP_WRITE_ENABLE_CMD, fwp_pkg::OP_WRDI,
                                      fwp_pkg::OP_DP, fwp_pkg::OP_SUSP_A,
                                      fwp_pkg::OP_SUSP_B, fwp_pkg::OP_RES_A,
                                      fwp_pkg::OP_RES_B}))
          next_st.write_enable_latch = 1'b0;
        next_st.reject = changes && !allow;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st      <= '0;
      st.mode <= fwp_pkg::FWP_STANDBY;
      st.bp   <= fwp_pkg::RST_BP;
      st.srp  <= fwp_pkg::RST_SRP;
      st.lb   <= fwp_pkg::RST_LB;
      st.cmp  <= fwp_pkg::RST_CMP;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

// file: bench/fwp_protect_chk.sv
// Checker for the write-protection block, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module fwp_protect_chk (
  input wire logic               i_ref_clk,
  input wire logic               i_rst,
  input wire fwp_pkg::fwp_bits_s i_bits,
  input wire logic               i_wp_n,
  input wire logic               i_op_done,
  input wire logic [15:0]        o_status,
  input wire fwp_pkg::fwp_op_s   o_op,
  input wire logic               o_reject
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  wire wr = o_op.valid && (o_op.kind != fwp_pkg::FWP_OP_SUSPEND)
    && (o_op.kind != fwp_pkg::FWP_OP_RESUME);
  wire ce = o_op.valid && (o_op.kind == fwp_pkg::FWP_OP_CHIP_ERASE);
  wire sw = o_op.valid && (o_op.kind == fwp_pkg::FWP_OP_STATUS);
  chk_reset_clear: assert property (disable iff (1'b0) i_rst |=> o_status == 16'h0000)
    else $error("status not clear after reset");
  chk_answer_cause: assert property ((o_op.valid || o_reject) |-> $past(i_bits.frame_end))
    else $error("answer without a frame end");
  chk_latch_needed: assert property (wr |-> $past(o_status[1]))
    else $error("write accepted with latch clear");
  chk_busy_refuse: assert property (wr |-> !$past(o_status[0]))
    else $error("write accepted while busy");
  chk_ce_clear: assert property (ce |-> ($past(o_status[14]) ?
    ($past(o_status[6]) ? $past(o_status[4:2]) == 3'h7 : $past(o_status[4])) :
    $past(o_status[4:2]) == 3'h0)) else $error("chip erase over protection");
  chk_wp_lock: assert property (sw |-> !($past(o_status[8:7]) == 2'b01 && !$past(i_wp_n)))
    else $error("status written with pin low");
  chk_guard_hi: assert property (sw |-> !$past(o_status[8]))
    else $error("status written while locked down");
  chk_suspend_flag: assert property (o_op.valid && o_op.kind == fwp_pkg::FWP_OP_SUSPEND
    |-> (o_status[15] || o_status[10])) else $error("suspend flag not set");
  chk_resume_clear: assert property (o_op.valid && o_op.kind == fwp_pkg::FWP_OP_RESUME
    |-> !o_status[15] && !o_status[10]) else $error("suspend flag not cleared");
  chk_lock_sticky: assert property (!$past(i_rst)
    |-> (($past(o_status[13:11]) & ~o_status[13:11]) == 3'h0)) else $error("lock bit cleared");
endmodule
bind fwp_protect fwp_protect_chk fwp_protect_chk_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_bits(i_bits), .i_wp_n(i_wp_n), .i_op_done(i_op_done), .o_status(o_status),
  .o_op(o_op), .o_reject(o_reject));

// file: bench/fwp_host_model.sv
// Host model: sends framed commands as bit strobes, MSB first.
// Assumes calls are made from one process at a time.
`timescale 1ns/100ps
module fwp_host_model (
  input  wire logic          i_ref_clk,
  output fwp_pkg::fwp_bits_s o_bits
);
  initial o_bits = '0;
  task automatic send(input logic [39:0] d, input int n);
    @(posedge i_ref_clk);
    o_bits.frame_start <= 1'b1;
    for (int k = n - 1; k >= 0; k--)
    begin
      @(posedge i_ref_clk);
      o_bits <= '{1'b0, 1'b1, d[k], 1'b0};
    end
    @(posedge i_ref_clk);
    // Data line no longer holds the last bit
    o_bits <= '{1'b0, 1'b0, !d[0], 1'b1};
    @(posedge i_ref_clk);
    o_bits <= '{1'b0, 1'b0, d[0], 1'b0};
  endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the write-protection block.
// Frames come from the host model; the done strobe is driven here.
`timescale 1ns/100ps
module testbench;
  logic               i_ref_clk = 1'b0;
  logic               i_rst = 1'b1;
  logic               i_wp_n = 1'b1;
  logic               i_op_done = 1'b0;
  fwp_pkg::fwp_bits_s bits;
  logic [15:0]        o_status;
  fwp_pkg::fwp_op_s   o_op;
  logic               o_reject;
  int                 mismatches = 0;
  int                 n_checks = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  fwp_host_model fwp_host_model_i (.i_ref_clk(i_ref_clk), .o_bits(bits));
  fwp_protect fwp_protect_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bits(bits),
    .i_wp_n(i_wp_n), .i_op_done(i_op_done), .o_status(o_status), .o_op(o_op),
    .o_reject(o_reject));
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic note(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_status(input logic [15:0] e, input logic [15:0] m);
    note("status", {48'h0, e}, {48'h0, o_status & m});
  endtask
  task automatic chk_resp(input logic v, input logic r);
    note("response", {62'h0, v, r}, {62'h0, o_op.valid, o_reject});
  endtask
  task automatic chk_span(input fwp_pkg::fwp_kind_e k, input logic [18:0] f,
                          input logic [18:0] l);
    note("span", {23'h0, k, f, l}, {23'h0, o_op.kind, o_op.first, o_op.last});
  endtask
  task automatic cmd(input logic [39:0] d, input int n);
    fwp_host_model_i.send(d, n);
    #1;
  endtask
  task automatic done;
    @(posedge i_ref_clk);
    i_op_done <= 1'b1;
    @(posedge i_ref_clk);
    i_op_done <= 1'b0;
    #1;
  endtask
  task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi, input logic acc);
    cmd(40'h06, 8);
    cmd({16'h0, fwp_pkg::OP_WRSR, lo, hi}, 24);
    chk_resp(acc, !acc);
    if (acc)
      done();
  endtask
  task automatic erase(input logic [7:0] op, input logic [18:0] a, input logic acc);
    logic [39:0] d;
    int          n;
    d = {8'h0, op, 5'h0, a};
    n = 32;
    if (op == fwp_pkg::OP_CE_A || op == fwp_pkg::OP_CE_B)
    begin
      d = {32'h0, op};
      n = 8;
    end
    if (op == fwp_pkg::OP_PP || op == fwp_pkg::OP_SEC_PROG)
    begin
      d = {op, 5'h0, a, 8'hA5};
      n = 40;
    end
    cmd(40'h06, 8);
    cmd(d, n);
    chk_resp(acc, !acc);
    if (acc)
      done();
  endtask
  task automatic prot(input logic c, input logic [4:0] bp, input logic [7:0] op,
                      input logic [18:0] a, input logic acc);
    logic [4:0]  lg;
    logic [18:0] m;
    wrsr({1'b0, bp, 2'h0}, {1'b0, c, 6'h0}, 1'b1);
    chk_status({1'b0, c, 6'h0, 1'b0, bp, 2'h0}, 16'hFFFF);
    erase(op, a, acc);
    lg = (op == fwp_pkg::OP_SE) ? fwp_pkg::LOG_SECT : (op == fwp_pkg::OP_BE32) ?
      fwp_pkg::LOG_BLK32 : (op == fwp_pkg::OP_BE64) ? fwp_pkg::LOG_BLK64 : fwp_pkg::LOG_PAGE;
    m = (19'h1 << lg) - 19'h1;
    if (acc && op != fwp_pkg::OP_CE_A && op != fwp_pkg::OP_CE_B)
      chk_span(op == fwp_pkg::OP_PP ? fwp_pkg::FWP_OP_PROGRAM : fwp_pkg::FWP_OP_ERASE,
               a & ~m, a | m);
  endtask
  initial
  begin
    #200000;
    mismatches++;
    test_done();
  end
  initial
  begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    chk_status(16'h0000, 16'hFFFF);
    cmd({8'h0, fwp_pkg::OP_SE, 24'h012345}, 32);
    chk_resp(1'b0, 1'b1);
    cmd(40'h06, 8);
    chk_status(16'h0002, 16'hFFFF);
    cmd({7'h0, fwp_pkg::OP_SE, 25'h0}, 33);
    chk_resp(1'b0, 1'b1);
    chk_status(16'h0002, 16'hFFFF);
    cmd({8'h0, fwp_pkg::OP_SE, 24'h012345}, 32);
    chk_span(fwp_pkg::FWP_OP_ERASE, 19'h12000, 19'h12FFF);
    chk_status(16'h0001, 16'hFFFF);
    cmd({32'h0, fwp_pkg::OP_SUSP_A}, 8);
    chk_status(16'h8000, 16'h8400);
    cmd({32'h0, fwp_pkg::OP_RES_A}, 8);
    chk_status(16'h0000, 16'h8400);
    done();
    cmd(40'h06, 8);
    cmd({fwp_pkg::OP_PP, 24'h000100, 8'h5A}, 40);
    cmd({32'h0, fwp_pkg::OP_SUSP_B}, 8);
    chk_status(16'h0400, 16'h8400);
    cmd({32'h0, fwp_pkg::OP_RES_B}, 8);
    chk_status(16'h0000, 16'h8400);
    done();
    prot(1'b0, 5'h01, fwp_pkg::OP_SE, 19'h70000, 1'b0);
    prot(1'b0, 5'h01, fwp_pkg::OP_SE, 19'h6F000, 1'b1);
    prot(1'b0, 5'h03, fwp_pkg::OP_SE, 19'h40000, 1'b0);
    prot(1'b0, 5'h03, fwp_pkg::OP_SE, 19'h3F000, 1'b1);
    prot(1'b0, 5'h0A, fwp_pkg::OP_SE, 19'h1F000, 1'b0);
    prot(1'b0, 5'h0A, fwp_pkg::OP_SE, 19'h20000, 1'b1);
    prot(1'b0, 5'h04, fwp_pkg::OP_SE, 19'h00000, 1'b0);
    prot(1'b0, 5'h18, fwp_pkg::OP_SE, 19'h00000, 1'b1);
    prot(1'b0, 5'h17, fwp_pkg::OP_SE, 19'h40000, 1'b0);
    prot(1'b0, 5'h11, fwp_pkg::OP_BE64, 19'h70000, 1'b0);
    prot(1'b0, 5'h11, fwp_pkg::OP_SE, 19'h7E000, 1'b1);
    prot(1'b0, 5'h15, fwp_pkg::OP_SE, 19'h78000, 1'b0);
    prot(1'b0, 5'h15, fwp_pkg::OP_BE32, 19'h70000, 1'b1);
    prot(1'b0, 5'h1B, fwp_pkg::OP_SE, 19'h03000, 1'b0);
    prot(1'b0, 5'h1B, fwp_pkg::OP_SE, 19'h04000, 1'b1);
    prot(1'b1, 5'h11, fwp_pkg::OP_SE, 19'h7E000, 1'b0);
    prot(1'b1, 5'h11, fwp_pkg::OP_SE, 19'h7F000, 1'b1);
    prot(1'b1, 5'h04, fwp_pkg::OP_SE, 19'h00000, 1'b1);
    prot(1'b1, 5'h00, fwp_pkg::OP_SE, 19'h7F000, 1'b0);
    prot(1'b1, 5'h1E, fwp_pkg::OP_SE, 19'h08000, 1'b0);
    prot(1'b1, 5'h1E, fwp_pkg::OP_PE, 19'h07F00, 1'b1);
    prot(1'b0, 5'h01, fwp_pkg::OP_CE_A, 19'h00000, 1'b0);
    prot(1'b1, 5'h04, fwp_pkg::OP_CE_B, 19'h00000, 1'b1);
    wrsr(8'h80, 8'h00, 1'b1);
    @(posedge i_ref_clk);
    i_wp_n <= 1'b0;
    wrsr(8'h04, 8'h00, 1'b0);
    chk_status(16'h0082, 16'hFFFF);
    @(posedge i_ref_clk);
    i_wp_n <= 1'b1;
    wrsr(8'h00, 8'h00, 1'b1);
    wrsr(8'h00, 8'h08, 1'b1);
    erase(fwp_pkg::OP_SEC_ERA, 19'h01000, 1'b0);
    erase(fwp_pkg::OP_SEC_PROG, 19'h02000, 1'b1);
    wrsr(8'h00, 8'h00, 1'b1);
    chk_status(16'h0800, 16'hFFFF);
    wrsr(8'h00, 8'h01, 1'b1);
    wrsr(8'h00, 8'h00, 1'b0);
    cmd({32'h0, fwp_pkg::OP_WRDI}, 8);
    chk_status(16'h0900, 16'hFFFF);
    cmd({32'h0, fwp_pkg::OP_DP}, 8);
    cmd(40'h06, 8);
    chk_status(16'h0900, 16'hFFFF);
    cmd({8'h0, fwp_pkg::OP_SE, 24'h000000}, 32);
    chk_resp(1'b0, 1'b0);
    cmd({32'h0, fwp_pkg::OP_RDP}, 8);
    cmd(40'h06, 8);
    chk_status(16'h0902, 16'hFFFF);
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    chk_status(16'h0000, 16'hFFFF);
    cmd(40'h06, 8);
    chk_status(16'h0002, 16'hFFFF);
    test_done();
  end
endmodule
